// *** hw/vcal_pkg.sv ***
package vcal_pkg;

   // fixed upper six bits of the first byte of every transfer
   localparam logic [5:0] ADDR_PATTERN = 6'h27;
   // first-byte field positions
   localparam int ADDR_RW_BIT = 0;
   localparam int ADDR_D0_BIT = 1;
   // second-byte field: program-select bit; code bits 7..1 sit above it
   localparam int DATA_PSEL_BIT = 0;
   // reset value of the code register before the power-up recall
   localparam logic [7:0] CODE_RESET = 8'h00;

   // program-cycle timing
   localparam int CLK_HZ = 25000000;
   localparam int PROG_LIMIT_MS = 100;
   localparam int PROG_LIMIT_CYC = (CLK_HZ / 1000) * PROG_LIMIT_MS;
   localparam int ERASE_MAX = 4;
   localparam int WRITE_MAX = 4;
   // default duration of a single erase or write pulse
   localparam int PULSE_MS = 10;
   localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;

   // serial engine states
   typedef enum logic [2:0]
   {
      VCAL_IDLE = 3'b000,
      VCAL_ADDR = 3'b001,
      VCAL_AACK = 3'b010,
      VCAL_WDAT = 3'b011,
      VCAL_DACK = 3'b100,
      VCAL_RDAT = 3'b101,
      VCAL_RACK = 3'b110
   } vcal_bus_e;

   // program sequencer states
   typedef enum logic [2:0]
   {
      VCAL_P_IDLE = 3'b000,
      VCAL_P_ERASE = 3'b001,
      VCAL_P_ECHK = 3'b010,
      VCAL_P_WRITE = 3'b011,
      VCAL_P_WCHK = 3'b100,
      VCAL_P_DONE = 3'b101
   } vcal_prog_e;

   // status seen at the top ports
   typedef struct packed
   {
      logic prog_busy;
      logic prog_fail;
      logic [2:0] erase_tries;
      logic [2:0] write_tries;
   } vcal_stat_s;

endpackage

// *** hw/vcal_port.sv ***
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - wp high: accept and act on transfers
// - wp low: ack register write, keep code
// - wp low: ack program, no cycle starts
// - read returns current code register value
// - psel one loads register, zero programs
// - program copies the code register
// - cycle completes regardless of wp, 100 ms
// - up to four erases, four writes
// - first byte is 100111, data, rw
// - first byte bit one is code lsb
// - power-up loads register from eeprom
module vcal_port
#(
   parameter int PROG_LIMIT = vcal_pkg::PROG_LIMIT_CYC,
   parameter int PULSE_LEN = vcal_pkg::PULSE_CYC
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // write-protect pin, active low
   input wire logic wp_n,
   // nonvolatile cell interface
   input wire logic [7:0] nv_rd_data,
   input wire logic nv_op_ok,
   output logic nv_erase,
   output logic nv_write,
   output logic [7:0] nv_wr_data,
   // code value and status
   output logic [7:0] potentiometer_code,
   output vcal_pkg::vcal_stat_s status
);

   //////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] pin_sync;
   logic scl_s, sda_s, wp_s;
   vcal_sync #(.WIDTH(3)) u_sync
   (
      .clk(ref_clk),
      .rst_n(rst_n),
      .async_in({scl_in, sda_in, wp_n}),
      .sync_out(pin_sync)
   );
   assign scl_s = pin_sync[2];
   assign sda_s = pin_sync[1];
   assign wp_s = pin_sync[0];

   logic scl_d_reg, sda_d_reg; // previous synchronised levels
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise = scl_s && !scl_d_reg;
   assign scl_fall = !scl_s && scl_d_reg;
   assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

   //////////////////////////////////////////////////////////////////////
   // serial engine
   vcal_pkg::vcal_bus_e st_reg;
   logic [7:0] shift_reg; // incoming bits, msb first
   logic [2:0] bit_reg; // bits taken in the current byte
   logic d0_reg; // code lsb carried in the first byte
   logic [7:0] code_reg; // the code register
   logic prog_req; // one-cycle program start
   logic [7:0] tx_reg; // outgoing read byte
   logic nack_reg; // host refused the read byte
   logic [7:0] rx_byte;
   assign rx_byte = {shift_reg[6:0], sda_s};

   // byte-level protocol; a start restarts from any state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= vcal_pkg::VCAL_IDLE;
         shift_reg <= 8'h00;
         bit_reg <= 3'h0;
         d0_reg <= 1'b0;
         tx_reg <= 8'h00;
         nack_reg <= 1'b0;
      end
      else if (start_cond)
      begin
         st_reg <= vcal_pkg::VCAL_ADDR;
         bit_reg <= 3'h0;
      end
      else if (stop_cond)
         st_reg <= vcal_pkg::VCAL_IDLE;
      else
      begin
         case (st_reg)
            vcal_pkg::VCAL_ADDR, vcal_pkg::VCAL_WDAT:
               if (scl_rise)
               begin
                  shift_reg <= rx_byte;
                  bit_reg <= bit_reg + 3'h1;
                  if (bit_reg == 3'h7)
                  begin
                     if (st_reg == vcal_pkg::VCAL_WDAT)
                        st_reg <= vcal_pkg::VCAL_DACK;
                     // pattern mismatch: stay off the bus
                     else if (rx_byte[7:2] != vcal_pkg::ADDR_PATTERN)
                        st_reg <= vcal_pkg::VCAL_IDLE;
                     else
                     begin
                        st_reg <= vcal_pkg::VCAL_AACK;
                        d0_reg <= rx_byte[vcal_pkg::ADDR_D0_BIT];
                     end
                  end
               end
            vcal_pkg::VCAL_AACK:
               // ack sampled on this rise; move on at the next fall
               if (scl_fall && bit_reg == 3'h1)
               begin
                  bit_reg <= 3'h0;
                  if (shift_reg[vcal_pkg::ADDR_RW_BIT])
                  begin
                     st_reg <= vcal_pkg::VCAL_RDAT;
                     tx_reg <= code_reg;
                  end
                  else
                     st_reg <= vcal_pkg::VCAL_WDAT;
               end
               else if (scl_rise)
                  bit_reg <= 3'h1;
            vcal_pkg::VCAL_DACK:
               // one data byte per transfer; further bytes are ignored
               if (scl_fall && bit_reg == 3'h1)
                  st_reg <= vcal_pkg::VCAL_IDLE;
               else if (scl_rise)
                  bit_reg <= 3'h1;
            vcal_pkg::VCAL_RDAT:
               if (scl_fall)
               begin
                  tx_reg <= {tx_reg[6:0], 1'b0};
                  bit_reg <= bit_reg + 3'h1;
                  if (bit_reg == 3'h7)
                     st_reg <= vcal_pkg::VCAL_RACK;
               end
            vcal_pkg::VCAL_RACK:
               if (scl_rise)
                  nack_reg <= sda_s;
               else if (scl_fall)
               begin
                  st_reg <= nack_reg ? vcal_pkg::VCAL_IDLE : vcal_pkg::VCAL_RDAT;
                  tx_reg <= code_reg;
                  bit_reg <= 3'h0;
               end
            default:
               st_reg <= vcal_pkg::VCAL_IDLE;
         endcase
      end
   end

   // a write byte is complete on the rise of its eighth bit
   logic wbyte_done;
   assign wbyte_done = !start_cond && !stop_cond && scl_rise
      && st_reg == vcal_pkg::VCAL_WDAT && bit_reg == 3'h7;

   // bus pin drive: ack low, or read data; released otherwise
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0;
         // acks are given whatever the write-protect level
         // the ack state is entered on the eighth rise while the clock is still high;
         // pulling the line then would look like a start, so wait for the fall
         if (st_reg == vcal_pkg::VCAL_AACK || st_reg == vcal_pkg::VCAL_DACK)
         begin
            // first fall ends the eighth bit, the next one ends the ack clock
            if (scl_fall)
               sda_oe <= (bit_reg == 3'h0);
         end
         else if (st_reg == vcal_pkg::VCAL_RDAT)
            sda_oe <= !tx_reg[7]; // open drain: drive only zeros
         else
            sda_oe <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // code register: power-up recall, then bus writes
   logic recall_reg; // recall pending after reset
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_reg <= vcal_pkg::CODE_RESET;
         recall_reg <= 1'b1;
         prog_req <= 1'b0;
      end
      else
      begin
         prog_req <= 1'b0;
         recall_reg <= 1'b0;
         if (recall_reg)
            code_reg <= nv_rd_data;
         else if (wbyte_done && wp_s)
         begin
            if (rx_byte[vcal_pkg::DATA_PSEL_BIT])
               code_reg <= {rx_byte[7:1], d0_reg};
            else
               prog_req <= 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // program sequencer; ignores wp once started
   vcal_pkg::vcal_prog_e pst_reg;
   logic [31:0] total_reg; // cycles since start
   logic [31:0] pulse_reg; // cycles in current pulse
   logic [2:0] etry_reg, wtry_reg;
   logic fail_reg;
   logic ok_reg; // latched success of current pulse
   // a timeout seen in a pulse still passes a check state and the done state
   localparam int PROG_MARGIN = 4;
   logic timeout;
   assign timeout = total_reg >= 32'(PROG_LIMIT - PROG_MARGIN);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pst_reg <= vcal_pkg::VCAL_P_IDLE;
         total_reg <= 32'h0;
         pulse_reg <= 32'h0;
         etry_reg <= 3'h0;
         wtry_reg <= 3'h0;
         fail_reg <= 1'b0;
         ok_reg <= 1'b0;
         nv_erase <= 1'b0;
         nv_write <= 1'b0;
         nv_wr_data <= 8'h00;
      end
      else
      begin
         if (pst_reg != vcal_pkg::VCAL_P_IDLE)
            total_reg <= total_reg + 32'h1;
         case (pst_reg)
            vcal_pkg::VCAL_P_IDLE:
               if (prog_req)
               begin
                  pst_reg <= vcal_pkg::VCAL_P_ERASE;
                  nv_wr_data <= code_reg;
                  total_reg <= 32'h0;
                  pulse_reg <= 32'h0;
                  etry_reg <= 3'h1;
                  wtry_reg <= 3'h0;
                  fail_reg <= 1'b0;
                  ok_reg <= 1'b0;
                  nv_erase <= 1'b1;
               end
            vcal_pkg::VCAL_P_ERASE, vcal_pkg::VCAL_P_WRITE:
            begin
               pulse_reg <= pulse_reg + 32'h1;
               if (nv_op_ok)
                  ok_reg <= 1'b1;
               if (pulse_reg >= 32'(PULSE_LEN - 1) || timeout)
               begin
                  nv_erase <= 1'b0;
                  nv_write <= 1'b0;
                  pst_reg <= (pst_reg == vcal_pkg::VCAL_P_ERASE) ?
                     vcal_pkg::VCAL_P_ECHK : vcal_pkg::VCAL_P_WCHK;
               end
            end
            vcal_pkg::VCAL_P_ECHK:
            begin
               pulse_reg <= 32'h0;
               ok_reg <= 1'b0;
               if (timeout)
               begin
                  fail_reg <= 1'b1;
                  pst_reg <= vcal_pkg::VCAL_P_DONE;
               end
               else if (ok_reg || etry_reg == 3'(vcal_pkg::ERASE_MAX))
               begin
                  fail_reg <= !ok_reg;
                  pst_reg <= ok_reg ? vcal_pkg::VCAL_P_WRITE : vcal_pkg::VCAL_P_DONE;
                  nv_write <= ok_reg;
                  wtry_reg <= ok_reg ? 3'h1 : 3'h0;
               end
               else
               begin
                  etry_reg <= etry_reg + 3'h1;
                  nv_erase <= 1'b1;
                  pst_reg <= vcal_pkg::VCAL_P_ERASE;
               end
            end
            vcal_pkg::VCAL_P_WCHK:
            begin
               pulse_reg <= 32'h0;
               ok_reg <= 1'b0;
               if (ok_reg || timeout || wtry_reg == 3'(vcal_pkg::WRITE_MAX))
               begin
                  fail_reg <= !ok_reg;
                  pst_reg <= vcal_pkg::VCAL_P_DONE;
               end
               else
               begin
                  wtry_reg <= wtry_reg + 3'h1;
                  nv_write <= 1'b1;
                  pst_reg <= vcal_pkg::VCAL_P_WRITE;
               end
            end
            vcal_pkg::VCAL_P_DONE:
               pst_reg <= vcal_pkg::VCAL_P_IDLE;
            default:
               pst_reg <= vcal_pkg::VCAL_P_IDLE;
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         potentiometer_code <= vcal_pkg::CODE_RESET;
         status <= '0;
      end
      else
      begin
         potentiometer_code <= code_reg;
         status.prog_busy <= pst_reg != vcal_pkg::VCAL_P_IDLE;
         status.prog_fail <= fail_reg;
         status.erase_tries <= etry_reg;
         status.write_tries <= wtry_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // checks
   AST_WP_LOW_NO_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wbyte_done && !wp_s && !recall_reg) |=> $stable(code_reg))
      else $error("code changed while write protected");
   AST_WP_LOW_NO_PROG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wbyte_done && !wp_s) |=> !prog_req)
      else $error("program started while write protected");
   AST_WP_HIGH_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wbyte_done && wp_s && !recall_reg && rx_byte[vcal_pkg::DATA_PSEL_BIT])
      |=> code_reg == {$past(rx_byte[7:1]), $past(d0_reg)})
      else $error("register write not taken");
   AST_PSEL_ZERO_PROG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wbyte_done && wp_s && !rx_byte[vcal_pkg::DATA_PSEL_BIT] && !recall_reg) |=> prog_req && $stable(code_reg))
      else $error("program select zero mishandled");
   AST_PROG_DATA: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (prog_req && pst_reg == vcal_pkg::VCAL_P_IDLE) |=> nv_wr_data == $past(code_reg) && nv_erase)
      else $error("program data not the code register");
   AST_PROG_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
      total_reg < 32'(PROG_LIMIT))
      else $error("program cycle overran its limit");
   AST_TRY_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      etry_reg <= 3'(vcal_pkg::ERASE_MAX) && wtry_reg <= 3'(vcal_pkg::WRITE_MAX))
      else $error("too many erase or write attempts");
   AST_RECALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      recall_reg |=> code_reg == $past(nv_rd_data))
      else $error("power-up recall missed");
   AST_READ_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg == vcal_pkg::VCAL_AACK && $past(st_reg) == vcal_pkg::VCAL_AACK && scl_fall
       && bit_reg == 3'h1 && shift_reg[0] && !start_cond && !stop_cond) |=> tx_reg == $past(code_reg))
      else $error("read byte not loaded from code register");
   // the data line may only move while the bus clock is low
   AST_SDA_SCL_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !$stable(sda_oe) |-> !scl_s)
      else $error("data line changed while bus clock high");

endmodule
`default_nettype wire

// *** hw/vcal_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for pin inputs
module vcal_sync
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // async in, sync out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg; // first stage, read only by the second

   //////////////////////////////////////////////////////////////////////
   // two stages per bit; idle level of the bus lines is high
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_reg[gi] <= 1'b1;
               sync_out[gi] <= 1'b1;
            end
            else
            begin
               meta_reg[gi] <= async_in[gi];
               sync_out[gi] <= meta_reg[gi];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// bench for the code register port: host model, cell model, reference model
module tb_top;
   // shortened program timing so the run stays brief
   localparam int PLIM = 400;
   localparam int PLEN = 20;
   logic ref_clk = 1'b0;
   logic rst_n, wp_n, nv_op_ok, scl, host_low, sda_out, sda_oe, nv_erase, nv_write;
   logic a1, a2, saw, er_d, wr_d;
   logic [7:0] nv_rd_data, nv_wr_data, code, d, d2, v, nv_store, exp_store, m_code;
   vcal_pkg::vcal_stat_s status;
   int bad_count, check_count, e_fail, w_fail, e_cnt, w_cnt, n, ee, we;
   wire logic sda_line;
   // open drain with pull-up: low if either party pulls
   assign sda_line = ~(host_low | (sda_oe & ~sda_out));

   always #20 ref_clk = ~ref_clk;

   vcal_host_model host_u (.clk(ref_clk), .sda(sda_line), .scl(scl), .sda_low(host_low));

   vcal_port #(.PROG_LIMIT(PLIM), .PULSE_LEN(PLEN)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wp_n(wp_n),
      .nv_rd_data(nv_rd_data), .nv_op_ok(nv_op_ok), .nv_erase(nv_erase), .nv_write(nv_write),
      .nv_wr_data(nv_wr_data), .potentiometer_code(code), .status(status));

   ////////////////////////////////////////////////////////////////////////////////
   // cell model: an attempt succeeds once the set number have failed
   always @(posedge ref_clk)
   begin
      #1;
      if (nv_erase === 1'b1 && !er_d) e_cnt++;
      if (nv_write === 1'b1 && !wr_d) w_cnt++;
      er_d = (nv_erase === 1'b1);
      wr_d = (nv_write === 1'b1);
      nv_op_ok = (er_d && e_cnt > e_fail) || (wr_d && w_cnt > w_fail);
      // a good write pulse stores whatever the port offers
      if (wr_d && nv_op_ok) nv_store = nv_wr_data;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: %0s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp, input string what);
      cmp8({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      #1;
      rst_n = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   // write: code lsb rides in the address byte, the rest with the select bit
   task automatic wr(input logic [7:0] c, input logic psel);
      host_u.start();
      host_u.byte_out({vcal_pkg::ADDR_PATTERN, c[0], 1'b0}, a1);
      host_u.byte_out({c[7:1], psel}, a2);
      host_u.stop();
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   // read a byte, ack it so the code byte repeats, then nack the second
   task automatic rd();
      host_u.start();
      host_u.byte_out({vcal_pkg::ADDR_PATTERN, 2'b01}, a1);
      host_u.byte_in(1'b1, d);
      host_u.byte_in(1'b0, d2);
      host_u.stop();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      nv_op_ok = 1'b0;
      er_d = 1'b0;
      wr_d = 1'b0;
      e_fail = 0;
      w_fail = 0;
      e_cnt = 0;
      w_cnt = 0;
      void'($urandom(26671));
      nv_store = 8'($urandom);
      nv_rd_data = nv_store;
      exp_store = nv_store;
      do_reset();
      cmp8(code, nv_store, "power-up recall");
      m_code = nv_store;
      $display("test recall done");
      // register writes with protection off, full-scale and lsb-only codes first
      for (int i = 0; i < 3; i++)
      begin
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($urandom);
         wr(v, 1'b1);
         m_code = v;
         cmp1(a1 & a2, 1'b1, "write ack");
         cmp8(code, m_code, "register write");
         rd();
         cmp1(a1, 1'b1, "read ack");
         cmp8(d, m_code, "read back");
         cmp8(d2, m_code, "repeated read");
      end
      $display("test write_read done");
      // protection on: acked but no effect, reads still work
      wp_n = 1'b0;
      wr(~m_code, 1'b1);
      cmp1(a1 & a2, 1'b1, "protected write ack");
      cmp8(code, m_code, "protected register");
      rd();
      cmp8(d, m_code, "protected read");
      cmp8(d2, m_code, "protected repeated read");
      wr(m_code ^ 8'h55, 1'b0);
      cmp1(a1 & a2, 1'b1, "protected program ack");
      saw = 1'b0;
      repeat (40)
      begin
         @(posedge ref_clk);
         #1;
         if (nv_erase === 1'b1 || status.prog_busy === 1'b1) saw = 1'b1;
      end
      cmp1(saw, 1'b0, "protected program start");
      cmp8(nv_store, exp_store, "protected store");
      wp_n = 1'b1;
      $display("test protect done");
      // foreign address pattern is not acked and changes nothing
      host_u.start();
      host_u.byte_out({vcal_pkg::ADDR_PATTERN ^ 6'h01, 2'b00}, a1);
      host_u.byte_out({~m_code[7:1], 1'b1}, a2);
      host_u.stop();
      repeat (4) @(posedge ref_clk);
      #1;
      cmp1(a1, 1'b0, "foreign address ack");
      cmp8(code, m_code, "foreign address register");
      $display("test address done");
      // program cycles with retries; protection turned on once running
      for (int i = 0; i < 4; i++)
      begin
         e_fail = (i == 2) ? 4 : i;
         w_fail = (i == 3) ? 4 : 3 - i;
         e_cnt = 0;
         w_cnt = 0;
         v = 8'($urandom);
         wr(v, 1'b1);
         m_code = v;
         wr(~v, 1'b0);
         wp_n = 1'b0;
         cmp1(status.prog_busy, 1'b1, "program started");
         n = 0;
         while (status.prog_busy !== 1'b0 && n < PLIM)
         begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         if (n >= PLIM)
         begin
            bad_count++;
            $display("mismatch at %0t: program cycle did not finish", $time);
            tally_and_finish();
         end
         wp_n = 1'b1;
         ee = (e_fail >= 4) ? 4 : e_fail + 1;
         we = (e_fail >= 4) ? 0 : (w_fail >= 4) ? 4 : w_fail + 1;
         if (e_fail < 4 && w_fail < 4) exp_store = m_code;
         cmp8(8'(e_cnt), 8'(ee), "erase pulses");
         cmp8(8'(w_cnt), 8'(we), "write pulses");
         cmp8({5'h00, status.erase_tries}, 8'(ee), "erase tries");
         cmp8({5'h00, status.write_tries}, 8'(we), "write tries");
         cmp1(status.prog_fail, (e_fail >= 4 || w_fail >= 4), "program fail");
         cmp8(nv_store, exp_store, "stored value");
         cmp8(code, m_code, "register kept");
      end
      $display("test program done");
      // mid-run reset recalls what was stored
      nv_rd_data = nv_store;
      do_reset();
      cmp8(code, exp_store, "reset recall");
      $display("test rerecall done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** sim/vcal_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// bus controller on the far side of the two-wire port
module vcal_host_model
(
   // bench clock, used only to pace the bus
   input wire logic clk,
   // resolved data line level
   input wire logic sda,
   // bus clock and data pull-down
   output logic scl,
   output logic sda_low
);
   // bus idles with both lines released high
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one quarter of the 320 ns bus period, always launched just after an edge
   task automatic q();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // start condition: data falls while the clock is high
   task automatic start();
      sda_low = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask

   // stop condition: data rises while the clock is high, bus left idle
   task automatic stop();
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask

   // one bit: data changes only while the clock is low, sampled mid-high
   task automatic bit_xfer(input logic b, output logic s);
      sda_low = ~b;
      q();
      scl = 1'b1;
      q();
      s = sda;
      q();
      scl = 1'b0;
      q();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // send a byte msb first, then release the line for the target's ack
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(d[i], s);
      end
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask

   // receive a byte msb first, then ack or nack it
   task automatic byte_in(input logic ack_host, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(~ack_host, s);
   endtask
endmodule
`default_nettype wire
